/* File: timer_defines.vh */
// register indexes, field positions and reset values of the dual timer
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH

// word indexes; byte address is four times the index
`define IDX_IRQ_STATUS 8'h54
`define IDX_IRQ_MASK 8'h55
`define IDX_T0_CONTROL 8'h58
`define IDX_T0_START 8'h59
`define IDX_T0_END 8'h5a
`define IDX_T0_CURRENT 8'h5b
`define IDX_T1_CONTROL 8'h5c
`define IDX_T1_START 8'h5d
`define IDX_T1_END 8'h5e
`define IDX_T1_CURRENT 8'h5f

// word index field of the byte address
`define IDX_MSB 9
`define IDX_LSB 2

// control register fields
`define CTL_ENABLE 0
`define CTL_RELOAD 1
`define CTL_STOP_DIS 2
`define CTL_DIR_UP 3
`define CTL_CLK_SEL 4
`define CTL_PRE_LSB 5
`define CTL_PRE_MSB 8
`define CTL_WIDTH 9

`define RST_VALUE16 16'h0000
`define RST_CONTROL 9'h000
`define RST_IRQ 2'h0
`define ONE16 16'h0001
`define ALL_ONES16 16'hffff
`define PRE_TOP 4'hf

`endif

/* File: sixteen_bit_updown_timer.v */
// dual 16-bit up/down timer with classic wishbone register access
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "timer_defines.vh"

module timer_channel #(
  parameter WIDTH = 16,
  parameter PRE_BITS = 4
)
(
  input wire clk,
  input wire srst,
  input wire enable,
  input wire reload,
  input wire stop_dis,
  input wire dir_up,
  input wire clk_sel,
  input wire [PRE_BITS-1:0] prescale,
  input wire ext_tick,
  input wire [WIDTH-1:0] start_value,
  input wire [WIDTH-1:0] end_value,
  output reg [WIDTH-1:0] count,
  output reg match_event
);

  reg [WIDTH-1:0] pre_cnt;
  reg enable_d;
  reg load_armed;
  wire [WIDTH-1:0] pre_mask;
  wire pre_tick;
  wire tick;
  wire at_end;
  wire start_edge;
  wire load_due;
  wire step;
  wire hold_at_end;
  wire reload_at_end;
  reg [WIDTH-1:0] next_count;

  // divide by 2^(prescale+1)
  assign pre_mask = `ALL_ONES16 >> (`PRE_TOP - prescale);
  assign pre_tick = (pre_cnt & pre_mask) == pre_mask;
  assign tick = clk_sel ? ext_tick : pre_tick;
  assign at_end = count == end_value;
  // a tick in the very cycle of the start edge loads at once
  assign start_edge = enable && !enable_d;
  assign load_due = load_armed || start_edge;
  assign step = enable && tick;
  assign hold_at_end = at_end && !stop_dis;
  assign reload_at_end = at_end && stop_dis && reload;

  always @(posedge clk)
  begin
    if (srst)
      pre_cnt <= `RST_VALUE16;
    else
      pre_cnt <= pre_cnt + `ONE16;
  end

  always @*
  begin
    next_count = count;
    if (step)
    begin
      if (load_due)
        next_count = start_value;
      else if (hold_at_end)
        next_count = count;
      else if (reload_at_end)
        next_count = start_value;
      else if (dir_up)
        next_count = count + `ONE16;
      else
        next_count = count - `ONE16;
    end
  end

  always @(posedge clk)
  begin
    if (srst)
      count <= `RST_VALUE16;
    else
      count <= next_count;
  end

  // the arm outlives the start edge until a tick or a disable
  always @(posedge clk)
  begin
    if (srst)
    begin
      enable_d <= 1'b0;
      load_armed <= 1'b0;
    end
    else
    begin
      enable_d <= enable;
      if (!enable || tick)
        load_armed <= 1'b0;
      else if (start_edge)
        load_armed <= 1'b1;
    end
  end

  // no match event on the start-edge tick that loads the start value; a reload at the end value does raise one
  always @(posedge clk)
  begin
    if (srst)
      match_event <= 1'b0;
    else
      match_event <= step && !load_due && at_end;
  end

endmodule

module sixteen_bit_updown_timer #(
  parameter ADR_WIDTH = 10
)
(
  input wire clk,
  input wire srst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [ADR_WIDTH-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire instruction_cycle_signal,
  output wire irq
);

  reg [`CTL_WIDTH-1:0] control0;
  reg [`CTL_WIDTH-1:0] control1;
  reg [15:0] start0;
  reg [15:0] start1;
  reg [15:0] end0;
  reg [15:0] end1;
  reg [1:0] irq_status;
  reg [1:0] irq_mask;
  reg cyc_sync1;
  reg cyc_sync2;
  reg cyc_prev;
  wire ext_tick;
  wire [15:0] count0;
  wire [15:0] count1;
  wire match0;
  wire match1;
  wire [7:0] idx;
  wire access;
  wire wr;
  wire [15:0] control0_merged;
  wire [15:0] control1_merged;
  wire wr_control0;
  wire wr_control1;
  wire wr_start0;
  wire wr_start1;
  wire wr_end0;
  wire wr_end1;
  wire wr_mask;
  wire wr_status;
  wire [1:0] match_bits;
  reg [31:0] rd_mux;

  // instruction cycle drives both external clocks, synchronised first
  always @(posedge clk)
  begin
    if (srst)
    begin
      cyc_sync1 <= 1'b0;
      cyc_sync2 <= 1'b0;
      cyc_prev <= 1'b0;
    end
    else
    begin
      cyc_sync1 <= instruction_cycle_signal;
      cyc_sync2 <= cyc_sync1;
      cyc_prev <= cyc_sync2;
    end
  end

  assign ext_tick = cyc_sync2 && !cyc_prev;

  timer_channel #(
    .WIDTH(16),
    .PRE_BITS(4)
  ) u_timer0 (
    .clk(clk),
    .srst(srst),
    .enable(control0[`CTL_ENABLE]),
    .reload(control0[`CTL_RELOAD]),
    .stop_dis(control0[`CTL_STOP_DIS]),
    .dir_up(control0[`CTL_DIR_UP]),
    .clk_sel(control0[`CTL_CLK_SEL]),
    .prescale(control0[`CTL_PRE_MSB:`CTL_PRE_LSB]),
    .ext_tick(ext_tick),
    .start_value(start0),
    .end_value(end0),
    .count(count0),
    .match_event(match0)
  );

  timer_channel #(
    .WIDTH(16),
    .PRE_BITS(4)
  ) u_timer1 (
    .clk(clk),
    .srst(srst),
    .enable(control1[`CTL_ENABLE]),
    .reload(control1[`CTL_RELOAD]),
    .stop_dis(control1[`CTL_STOP_DIS]),
    .dir_up(control1[`CTL_DIR_UP]),
    .clk_sel(control1[`CTL_CLK_SEL]),
    .prescale(control1[`CTL_PRE_MSB:`CTL_PRE_LSB]),
    .ext_tick(ext_tick),
    .start_value(start1),
    .end_value(end1),
    .count(count1),
    .match_event(match1)
  );

  assign idx = wb_adr_i[`IDX_MSB:`IDX_LSB];
  assign access = wb_cyc_i && wb_stb_i;
  // write lands on the edge where the master sees ack
  assign wr = access && wb_we_i && wb_ack_o;

  function [15:0] lane_merge;
    input [15:0] old;
    input [31:0] din;
    input [3:0] sel;
    begin
      lane_merge[7:0] = sel[0] ? din[7:0] : old[7:0];
      lane_merge[15:8] = sel[1] ? din[15:8] : old[15:8];
    end
  endfunction

  assign control0_merged = lane_merge({7'h00, control0}, wb_dat_i, wb_sel_i);
  assign control1_merged = lane_merge({7'h00, control1}, wb_dat_i, wb_sel_i);

  // one write strobe per register; read-only and unmapped words drop the write
  assign wr_control0 = wr && idx == `IDX_T0_CONTROL;
  assign wr_control1 = wr && idx == `IDX_T1_CONTROL;
  assign wr_start0 = wr && idx == `IDX_T0_START;
  assign wr_start1 = wr && idx == `IDX_T1_START;
  assign wr_end0 = wr && idx == `IDX_T0_END;
  assign wr_end1 = wr && idx == `IDX_T1_END;
  assign wr_mask = wr && idx == `IDX_IRQ_MASK && wb_sel_i[0];
  assign wr_status = wr && idx == `IDX_IRQ_STATUS && wb_sel_i[0];
  assign match_bits = {match1, match0};

  always @(posedge clk)
  begin
    if (srst)
      control0 <= `RST_CONTROL;
    else if (wr_control0)
      control0 <= control0_merged[`CTL_WIDTH-1:0];
  end

  always @(posedge clk)
  begin
    if (srst)
      control1 <= `RST_CONTROL;
    else if (wr_control1)
      control1 <= control1_merged[`CTL_WIDTH-1:0];
  end

  always @(posedge clk)
  begin
    if (srst)
      start0 <= `RST_VALUE16;
    else if (wr_start0)
      start0 <= lane_merge(start0, wb_dat_i, wb_sel_i);
  end

  always @(posedge clk)
  begin
    if (srst)
      start1 <= `RST_VALUE16;
    else if (wr_start1)
      start1 <= lane_merge(start1, wb_dat_i, wb_sel_i);
  end

  always @(posedge clk)
  begin
    if (srst)
      end0 <= `RST_VALUE16;
    else if (wr_end0)
      end0 <= lane_merge(end0, wb_dat_i, wb_sel_i);
  end

  always @(posedge clk)
  begin
    if (srst)
      end1 <= `RST_VALUE16;
    else if (wr_end1)
      end1 <= lane_merge(end1, wb_dat_i, wb_sel_i);
  end

  always @(posedge clk)
  begin
    if (srst)
      irq_mask <= `RST_IRQ;
    else if (wr_mask)
      irq_mask <= wb_dat_i[1:0];
  end

  // sticky match flags; a new match wins over a write-one clear
  always @(posedge clk)
  begin
    if (srst)
      irq_status <= `RST_IRQ;
    else if (wr_status)
      irq_status <= (irq_status & ~wb_dat_i[1:0]) | match_bits;
    else
      irq_status <= irq_status | match_bits;
  end

  assign irq = |(irq_status & irq_mask);

  always @*
  begin
    case (idx)
      `IDX_T0_CONTROL:
        rd_mux = {23'h000000, control0};
      `IDX_T1_CONTROL:
        rd_mux = {23'h000000, control1};
      `IDX_T0_START:
        rd_mux = {16'h0000, start0};
      `IDX_T1_START:
        rd_mux = {16'h0000, start1};
      `IDX_T0_END:
        rd_mux = {16'h0000, end0};
      `IDX_T1_END:
        rd_mux = {16'h0000, end1};
      `IDX_T0_CURRENT:
        rd_mux = {16'h0000, count0};
      `IDX_T1_CURRENT:
        rd_mux = {16'h0000, count1};
      `IDX_IRQ_STATUS:
        rd_mux = {30'h00000000, irq_status};
      `IDX_IRQ_MASK:
        rd_mux = {30'h00000000, irq_mask};
      default:
        rd_mux = 32'h00000000;
    endcase
  end

  // one-cycle ack for every address; unmapped reads return zero
  always @(posedge clk)
  begin
    if (srst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= access && !wb_ack_o;
      wb_dat_o <= rd_mux;
    end
  end

endmodule

/* File: timer_chk.sv */
// bus and interrupt checks of the dual timer
`timescale 1ns/1ps
module timer_chk #(
  parameter ADR_WIDTH = 10
)
(
  input wire clk,
  input wire srst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [ADR_WIDTH-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire instruction_cycle_signal,
  input wire irq
);
  logic [15:0] sv;
  wire rda = wb_ack_o && !wb_we_i;
  wire [7:0] ix = wb_adr_i[9:2];
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // last timer 0 start value written
  always @(posedge clk)
    if (srst)
      sv <= 16'h0000;
    else if (wb_ack_o && wb_we_i && ix == 8'h59)
      sv <= wb_dat_i[15:0];
  ack_quick_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  unmapped_zero_a: assert property (rda && (ix == 8'h56 || ix == 8'h57) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  start_back_a: assert property (rda && ix == 8'h59 |-> wb_dat_o[15:0] == sv)
    else $error("start value readback wrong");
  irq_reset_a: assert property ($past(srst) |-> !irq)
    else $error("irq after reset");
  irq_fall_a: assert property ($fell(irq) |-> $past(wb_ack_o && wb_we_i) || $past(srst))
    else $error("irq fell without write");
  cover property (irq);
  cover property (rda && wb_dat_o != 32'h0);
  cover property (wb_ack_o && wb_we_i);
endmodule
bind sixteen_bit_updown_timer timer_chk #(.ADR_WIDTH(ADR_WIDTH)) i_timer_chk (.clk(clk),
  .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .instruction_cycle_signal(instruction_cycle_signal), .irq(irq));

/* File: tb_top.sv */
// self-checking bench of the dual timer
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [7:0] b; logic [15:0] c, s, e; int n; logic [15:0] x;} row_t;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] dat = 32'h0;
  logic pin = 1'b0;
  logic [31:0] dout;
  logic ack;
  logic irq;
  logic [31:0] rq;
  int mismatches = 0;
  int checked = 0;
  row_t rows[6] = '{
    '{8'h58, 16'h001d, 16'h0010, 16'h0100, 4, 16'h0013},
    '{8'h5c, 16'h0015, 16'h0010, 16'h0000, 4, 16'h000d},
    '{8'h58, 16'h0019, 16'h0010, 16'h0012, 6, 16'h0012},
    '{8'h5c, 16'h001f, 16'h0010, 16'h0012, 5, 16'h0011},
    '{8'h58, 16'h001d, 16'hfffe, 16'hffff, 4, 16'h0001},
    '{8'h58, 16'h0015, 16'h0001, 16'h0005, 4, 16'hfffe}};
  sixteen_bit_updown_timer i_sixteen_bit_updown_timer (
    .clk(clk),
    .srst(srst),
    .wb_cyc_i(cyc),
    .wb_stb_i(cyc),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(4'h3),
    .wb_dat_i(dat),
    .wb_dat_o(dout),
    .wb_ack_o(ack),
    .instruction_cycle_signal(pin),
    .irq(irq)
  );
  always #2.5 clk = ~clk;
  task automatic wrap_up;
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= {a, 2'b00};
    dat <= {16'h0000, d};
    @(posedge clk);
    while (ack !== 1'b1)
    begin
      @(posedge clk);
      n++;
    end
    chk("ack wait", n, 32'h1);
    rq = dout;
    cyc <= 1'b0;
    @(posedge clk);
  endtask
  // external count pulses, then settle past the synchroniser
  task automatic tick(input int n);
    repeat (n)
    begin
      pin <= 1'b1;
      repeat (2) @(posedge clk);
      pin <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int i = 8'h54; i < 8'h60; i++)
    begin
      wb(0, i[7:0], 0);
      chk("reset", rq, 32'h0);
    end
    wb(1, 8'h5b, 16'h1234);
    wb(0, 8'h5b, 0);
    chk("current", rq, 32'h0);
    wb(1, 8'h59, 16'ha5c3);
    wb(0, 8'h59, 0);
    chk("start", rq, 32'ha5c3);
    foreach (rows[k])
    begin
      wb(1, rows[k].b, 0);
      wb(1, rows[k].b + 8'h1, rows[k].s);
      wb(1, rows[k].b + 8'h2, rows[k].e);
      wb(1, rows[k].b, rows[k].c);
      tick(rows[k].n);
      wb(0, rows[k].b + 8'h3, 0);
      chk("count", rq, {16'h0, rows[k].x});
    end
    wb(1, 8'h58, 16'h0014);
    tick(3);
    wb(0, 8'h5b, 0);
    chk("held", rq, 32'hfffe);
    wb(1, 8'h59, 16'h0000);
    wb(1, 8'h5a, 16'h0003);
    wb(1, 8'h58, 16'h0009);
    repeat (40) @(posedge clk);
    wb(0, 8'h5b, 0);
    chk("internal", rq, 32'h3);
    wb(1, 8'h5c, 16'h0000);
    wb(1, 8'h5d, 16'h0005);
    wb(1, 8'h5e, 16'h0007);
    wb(1, 8'h5c, 16'h0069);
    repeat (12) @(posedge clk);
    wb(0, 8'h5f, 0);
    chk("prescaled early", {31'h0, rq == 32'h7}, 32'h0);
    repeat (60) @(posedge clk);
    wb(0, 8'h5f, 0);
    chk("prescaled", rq, 32'h7);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wb(1, 8'h55, 16'h0001);
    chk("irq", {31'h0, irq}, 32'h1);
    wb(1, 8'h58, 16'h0000);
    wb(1, 8'h54, 16'h0001);
    wb(0, 8'h54, 0);
    chk("status", rq & 32'h1, 32'h0);
    chk("irq off", {31'h0, irq}, 32'h0);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    wb(0, 8'h59, 0);
    chk("start reset", rq, 32'h0);
    wrap_up;
  end
  initial
  begin
    #20us;
    mismatches++;
    wrap_up;
  end
endmodule
